// ### src/sop_pkg.sv
// Constants and types for the serial output port
package sop_pkg;
   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_FORMAT = 8'hA4;
   localparam logic [7:0] OFS_PORTCFG = 8'hA9;
   localparam logic [7:0] OFS_FRAME = 8'hAA;
   localparam logic [7:0] OFS_STATUS = 8'hAB;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int FMT_SCALE_LSB = 0;
   localparam int FMT_KIND_LSB = 4;
   localparam int FMT_FIXED_BIT = 6;
   localparam int FMT_COMMON_BIT = 7;
   localparam int CFG_DIV_LSB = 0;
   localparam int CFG_MASTER_BIT = 4;
   localparam int FRM_PREC_LSB = 0;
   localparam int FRM_FSMODE_LSB = 2;
   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_FORMAT = 8'h00;
   localparam logic [4:0] RST_PORTCFG = 5'h01;
   localparam logic [3:0] RST_FRAME = 4'h0;
   // ----------------------------------------------------------------
   // Encodings
   // ----------------------------------------------------------------
   localparam logic [1:0] KIND_LINEAR = 2'h0;
   localparam logic [1:0] KIND_FLT8 = 2'h1;
   localparam logic [1:0] KIND_FLT12 = 2'h2;
   localparam logic [1:0] PREC_12 = 2'h0;
   localparam logic [1:0] PREC_16 = 2'h1;
   localparam logic [1:0] PREC_24 = 2'h2;
   localparam logic [5:0] BITS_12 = 6'h0C;
   localparam logic [5:0] BITS_16 = 6'h10;
   localparam logic [5:0] BITS_24 = 6'h18;
   localparam logic [5:0] BITS_COMPACT = 6'h14;
   localparam logic [3:0] EXP_MAX = 4'hF;
   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {FS_ONE_BEFORE, FS_WHOLE_FRAME, FS_PER_WORD}
      sop_fsmode_t;
   typedef enum {ST_IDLE, ST_PRE, ST_SHIFT} sop_state_t;
   typedef struct packed {
      logic [23:0] i;
      logic [23:0] q;
   } sop_iq_t;
endpackage : sop_pkg

// ### src/sop_port.sv
// Serial output port of one receive channel
//
// Contract
// - I and Q words 12, 16 or 24 bits
// - Float output 8+4 or 12+4 available
// - Linear scaled by 4-bit or fixed factor
// - Every word leaves MSB first
// - Auto exponent, optional shared I/Q exponent
// - Compact: I mant, I exp, Q mant
// - Compact when decimation 20, 8+4, common
// - Master sync on next serial rising edge
// - Mode one: sync one clock before data
// - Mode two: sync high during all bits
// - Mode three: sync before I and Q
// - Frame end during last Q bit
// - Data ready while buffer holds sample
// - Slave sync sampled, shift next edge
// - Master drives clock, sync; slave receives
// - Port zero strap, others slave by default
// - Serial clock is clock over divider+1, divider 0 taken as 1
// - Config bit 4 selects master on ports other than port zero
// - Data line released when not shifting
//
// Chosen here: the strobed register port.
`timescale 1ns/100ps
module sop_port #(
   parameter int PORT_INDEX = 1,
   parameter logic [3:0] FIXED_SCALE = 4'h0
) (
   // Clock and reset
   input wire logic I_CLK,
   input wire logic I_RST_B,
   // Register port
   input wire logic [7:0] I_ADDR,
   input wire logic [7:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic [7:0] O_RDATA,
   // Filter side
   input wire logic I_SAMPLE_VALID,
   input wire sop_pkg::sop_iq_t I_SAMPLE,
   input wire logic I_DECIM_IS_20,
   // Straps
   input wire logic I_PORT_ZERO_MASTER_STRAP,
   input wire logic [3:0] I_PORT_ZERO_DIVIDER,
   // Serial link
   input wire logic I_SCLK,
   output logic O_SCLK,
   output logic O_SCLK_OE_B,
   input wire logic I_FRAME_SYNC,
   output logic O_FRAME_SYNC,
   output logic O_FRAME_SYNC_OE_B,
   output logic O_SERIAL_OUT_LINE,
   output logic O_SERIAL_OUT_LINE_OE_B,
   output logic O_FRAME_END,
   output logic O_DATA_READY_FLAG
);
   import sop_pkg::*;

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------
   function automatic logic [3:0] lead_bits(input logic [23:0] s);
      logic [3:0] n;
      logic run;
      n = 4'h0;
      run = 1'b1;
      for (int k = 22; k >= 0; k--) begin
         if (run && s[k] == s[23] && n != EXP_MAX) begin
            n = n + 4'h1;
         end else begin
            run = 1'b0;
         end
      end
      return n;
   endfunction : lead_bits

   function automatic logic [23:0] float_word(input logic [23:0] s,
         input logic [3:0] e, input logic wide);
      logic [23:0] norm;
      norm = s << e;
      if (wide) begin
         return {norm[23:12], e, 8'h00};
      end
      return {norm[23:16], e, 12'h000};
   endfunction : float_word

   function automatic logic [5:0] prec_bits(input logic [1:0] p);
      unique case (p)
         PREC_16: return BITS_16;
         PREC_24: return BITS_24;
         default: return BITS_12;
      endcase
   endfunction : prec_bits

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [7:0] format_ctl;
   logic [4:0] port_cfg;
   logic [3:0] frame_ctl, strap_div;
   logic strap_master, strap_taken;
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         format_ctl <= RST_FORMAT;
         port_cfg <= RST_PORTCFG;
         frame_ctl <= RST_FRAME;
      end else if (I_WR) begin
         if (I_ADDR == OFS_FORMAT) begin
            format_ctl <= I_WDATA;
         end
         if (I_ADDR == OFS_PORTCFG) begin
            port_cfg <= I_WDATA[4:0];
         end
         if (I_ADDR == OFS_FRAME) begin
            frame_ctl <= I_WDATA[3:0];
         end
      end
   end

   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         strap_taken <= 1'b0;
         strap_master <= 1'b0;
         strap_div <= 4'h1;
      end else if (!strap_taken) begin
         strap_taken <= 1'b1;
         strap_master <= I_PORT_ZERO_MASTER_STRAP;
         strap_div <= I_PORT_ZERO_DIVIDER;
      end
   end

   logic master, compact;
   logic [3:0] div_raw, div_eff;
   logic [5:0] prec, total;
   sop_fsmode_t fs_mode;
   assign master = (PORT_INDEX == 0) ? strap_master :
      port_cfg[CFG_MASTER_BIT];
   assign div_raw = (PORT_INDEX == 0) ? strap_div :
      port_cfg[CFG_DIV_LSB +: 4];
   assign div_eff = (div_raw == 4'h0) ? 4'h1 : div_raw;
   assign prec = prec_bits(frame_ctl[FRM_PREC_LSB +: 2]);
   assign compact = I_DECIM_IS_20 &&
      format_ctl[FMT_KIND_LSB +: 2] == KIND_FLT8 &&
      format_ctl[FMT_COMMON_BIT];
   assign total = compact ? BITS_COMPACT : {prec[4:0], 1'b0};
   assign fs_mode = sop_fsmode_t'(frame_ctl[FRM_FSMODE_LSB +: 2]);

   // ----------------------------------------------------------------
   // Serial clock
   // ----------------------------------------------------------------
   logic [3:0] div_cnt;
   logic sclk_q, sck_rise;
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         div_cnt <= 4'h0;
      end else if (!master || div_cnt >= div_eff) begin
         div_cnt <= 4'h0;
      end else begin
         div_cnt <= div_cnt + 4'h1;
      end
   end

   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         O_SCLK <= 1'b0;
         sclk_q <= 1'b0;
      end else begin
         O_SCLK <= master && (div_cnt >= div_eff ||
            (div_cnt + 4'h1) <= (div_eff >> 1));
         sclk_q <= I_SCLK;
      end
   end

   assign sck_rise = master ? (div_cnt >= div_eff) : (I_SCLK && !sclk_q);

   // ----------------------------------------------------------------
   // Sample buffer and formatting
   // ----------------------------------------------------------------
   logic [23:0] buf_i, buf_q, next_i, next_q;
   logic buf_full, start;
   logic [3:0] scale, exp_i, exp_q;
   always_comb begin
      scale = format_ctl[FMT_FIXED_BIT] ? FIXED_SCALE :
         format_ctl[FMT_SCALE_LSB +: 4];
      exp_i = lead_bits(I_SAMPLE.i);
      exp_q = lead_bits(I_SAMPLE.q);
      if (format_ctl[FMT_COMMON_BIT]) begin
         if (exp_q < exp_i) begin
            exp_i = exp_q;
         end
         exp_q = exp_i;
      end
      unique case (format_ctl[FMT_KIND_LSB +: 2])
         KIND_FLT8: begin
            next_i = float_word(I_SAMPLE.i, exp_i, 1'b0);
            next_q = float_word(I_SAMPLE.q, exp_q, 1'b0);
         end
         KIND_FLT12: begin
            next_i = float_word(I_SAMPLE.i, exp_i, 1'b1);
            next_q = float_word(I_SAMPLE.q, exp_q, 1'b1);
         end
         default: begin
            next_i = I_SAMPLE.i << scale;
            next_q = I_SAMPLE.q << scale;
         end
      endcase
      // compact packs Q after I exponent
      if (compact) begin
         next_i = {next_i[23:12], next_q[23:16], 4'h0};
      end
   end

   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         buf_i <= 24'h000000;
         buf_q <= 24'h000000;
      end else if (I_SAMPLE_VALID) begin
         buf_i <= next_i;
         buf_q <= next_q;
      end
   end

   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         buf_full <= 1'b0;
      end else begin
         buf_full <= I_SAMPLE_VALID || (buf_full && !start);
      end
   end
   assign O_DATA_READY_FLAG = buf_full;

   // ----------------------------------------------------------------
   // Frame sequencer
   // ----------------------------------------------------------------
   sop_state_t state;
   logic [23:0] sh_i, sh_q;
   logic [5:0] bit_idx, q_len, q_pos;
   logic shifting, cur_bit, fs_drive;
   assign q_len = compact ? BITS_COMPACT : prec;
   assign q_pos = bit_idx - q_len;
   assign shifting = (state == ST_SHIFT);
   assign cur_bit = (bit_idx < q_len) ? sh_i[5'(6'd23 - bit_idx)] :
      sh_q[5'(6'd23 - q_pos)];
   assign start = sck_rise && buf_full && state == ST_IDLE &&
      (master || I_FRAME_SYNC);

   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         state <= ST_IDLE;
         sh_i <= 24'h000000;
         sh_q <= 24'h000000;
      end else if (start) begin
         sh_i <= buf_i;
         sh_q <= buf_q;
         state <= (master && fs_mode == FS_WHOLE_FRAME) ? ST_SHIFT :
            ST_PRE;
      end else if (sck_rise) begin
         unique case (state)
            ST_PRE: state <= ST_SHIFT;
            ST_SHIFT: begin
               if (bit_idx == total - 6'h01) begin
                  state <= ST_IDLE;
               end
            end
            ST_IDLE: state <= ST_IDLE;
         endcase
      end
   end

   // Bit counter and pins
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         bit_idx <= 6'h00;
      end else if (start || (sck_rise && state == ST_PRE)) begin
         bit_idx <= 6'h00;
      end else if (sck_rise && shifting) begin
         bit_idx <= bit_idx + 6'h01;
      end
   end

   always_comb begin
      fs_drive = 1'b0;
      if (master) begin
         unique case (fs_mode)
            FS_WHOLE_FRAME: fs_drive = shifting;
            FS_PER_WORD: fs_drive = state == ST_PRE ||
               (shifting && bit_idx == q_len - 6'h01);
            default: fs_drive = state == ST_PRE;
         endcase
      end
   end

   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         O_FRAME_SYNC <= 1'b0;
         O_SERIAL_OUT_LINE <= 1'b0;
         O_FRAME_END <= 1'b0;
      end else begin
         O_FRAME_SYNC <= fs_drive;
         O_SERIAL_OUT_LINE <= shifting && cur_bit;
         O_FRAME_END <= shifting && bit_idx == total - 6'h01;
      end
   end

   assign O_SCLK_OE_B = !master;
   assign O_FRAME_SYNC_OE_B = !master;

   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         O_SERIAL_OUT_LINE_OE_B <= 1'b1;
      end else begin
         O_SERIAL_OUT_LINE_OE_B <= !shifting;
      end
   end

   // ----------------------------------------------------------------
   // Register read
   // ----------------------------------------------------------------
   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         O_RDATA <= 8'h00;
      end else if (I_RD) begin
         unique case (I_ADDR)
            OFS_FORMAT: O_RDATA <= format_ctl;
            OFS_PORTCFG: O_RDATA <= {3'h0, master, div_raw};
            OFS_FRAME: O_RDATA <= {4'h0, frame_ctl};
            OFS_STATUS: O_RDATA <= {5'h00, master, shifting, buf_full};
            default: O_RDATA <= 8'h00;
         endcase
      end else begin
         O_RDATA <= 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (!I_RST_B);

   ready_set_a: assert property (I_SAMPLE_VALID |=> O_DATA_READY_FLAG)
      else $error("ready not raised after load");
   ready_clear_a: assert property (
      (start && !I_SAMPLE_VALID) |=> !O_DATA_READY_FLAG)
      else $error("ready stayed high after frame start");
   msb_first_a: assert property (
      $rose(shifting) |=> O_SERIAL_OUT_LINE == sh_i[23])
      else $error("first bit is not the MSB");
   fs_whole_a: assert property (
      (master && fs_mode == FS_WHOLE_FRAME && shifting) |=> O_FRAME_SYNC)
      else $error("sync low during frame");
   fs_before_a: assert property (
      (master && fs_mode == FS_ONE_BEFORE && $fell(O_SERIAL_OUT_LINE_OE_B))
      |-> $past(O_FRAME_SYNC) && !O_FRAME_SYNC)
      else $error("sync not one clock before data");
   frame_end_a: assert property (
      O_FRAME_END |-> $past(shifting) && $past(bit_idx) == total - 6'h01)
      else $error("frame end off last bit");
   sdo_release_a: assert property (
      !$past(shifting) |-> O_SERIAL_OUT_LINE_OE_B)
      else $error("data line driven while idle");
   slave_pins_a: assert property (
      !master |-> O_SCLK_OE_B && O_FRAME_SYNC_OE_B && !O_FRAME_SYNC)
      else $error("slave drives clock or sync");
   sclk_rate_a: assert property (
      (master && sck_rise && $stable(div_eff)) |=> !sck_rise [*1])
      else $error("serial clock faster than divider allows");
   compact_len_a: assert property (
      (compact && O_FRAME_END) |-> $past(bit_idx) == BITS_COMPACT - 6'h01)
      else $error("compact frame not twenty bits");

   mode1_c: cover property (master && fs_mode == FS_ONE_BEFORE && start);
   mode3_c: cover property (master && fs_mode == FS_PER_WORD && O_FRAME_END);
   slave_c: cover property (!master && start);
   compact_c: cover property (compact && O_FRAME_END);
endmodule : sop_port

// ### test/sop_dsp_model.sv
// Behavioural DSP serial port facing the output port
`timescale 1ns/100ps
module sop_dsp_model (
   // Clock and control
   input wire logic clk,
   input wire logic rst_b,
   input wire logic go,
   input wire logic clr,
   input wire logic [5:0] nper,
   // Serial lines as seen on the wire
   input wire logic sclk,
   input wire logic fs,
   input wire logic sdo,
   input wire logic sdo_oe_b,
   input wire logic fe,
   // Slave-mode drive and capture
   output logic sclk_s,
   output logic fs_s,
   output logic [63:0] rx,
   output logic [63:0] fsr,
   output logic [63:0] fer,
   output logic [6:0] cnt
);
   logic [1:0] ph;
   logic [6:0] left;
   logic sclk_q;
   // ----------------------------------------------------------------
   // Slave clock and sync
   // ----------------------------------------------------------------
   // sync before clock
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ph <= 2'h0;
         left <= 7'h00;
         sclk_s <= 1'b0;
         fs_s <= 1'b0;
      end else if (go) begin
         ph <= 2'h0;
         left <= 7'(nper) + 7'h01;
         fs_s <= 1'b1;
      end else if (left != 7'h00) begin
         ph <= ph + 2'h1;
         if (ph == 2'h1) begin
            sclk_s <= 1'b1;
            fs_s <= (left == 7'(nper) + 7'h01);
         end
         if (ph == 2'h3) begin
            sclk_s <= 1'b0;
            left <= left - 7'h01;
         end
      end
   end
   // ----------------------------------------------------------------
   // Capture on falling serial edge
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sclk_q <= 1'b0;
         rx <= 64'h0;
         fsr <= 64'h0;
         fer <= 64'h0;
         cnt <= 7'h00;
      end else begin
         sclk_q <= sclk;
         if (clr) begin
            rx <= 64'h0;
            fsr <= 64'h0;
            fer <= 64'h0;
            cnt <= 7'h00;
         end else if (sclk_q && !sclk && (fs || !sdo_oe_b)) begin
            rx <= {rx[62:0], sdo & !sdo_oe_b};
            fsr <= {fsr[62:0], fs};
            fer <= {fer[62:0], fe};
            cnt <= cnt + 7'h01;
         end
      end
   end
endmodule : sop_dsp_model

// ### test/sop_port_tb_top.sv
// Self-checking bench for the serial output port
`timescale 1ns/100ps
module sop_port_tb_top;
   import sop_pkg::*;
   localparam logic [23:0] I0 = 24'hA5C3E1;
   localparam logic [23:0] Q0 = 24'h3C5A96;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic valid = 1'b0;
   sop_iq_t sample = '0;
   logic decim20 = 1'b0;
   logic go = 1'b0;
   logic clr = 1'b0;
   logic [7:0] rdata;
   logic [7:0] rdata0;
   logic sclk0_oe_b;
   logic sclk_m, sclk_oe_b, fs_m, fs_oe_b, sdo, sdo_oe_b, fe, ready;
   logic sclk_s, fs_s, sclk_w, fs_w;
   logic [63:0] rx, fsr, fer;
   logic [6:0] cnt;
   int err_count = 0;
   int n_tests = 0;
   assign sclk_w = sclk_oe_b ? sclk_s : sclk_m;
   assign fs_w = fs_oe_b ? fs_s : fs_m;
   always #10 clk = ~clk;
   sop_port #(.PORT_INDEX(1), .FIXED_SCALE(4'h2)) dut (
      .I_CLK(clk), .I_RST_B(rst_b), .I_ADDR(addr), .I_WDATA(wdata),
      .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_SAMPLE_VALID(valid),
      .I_SAMPLE(sample), .I_DECIM_IS_20(decim20),
      .I_PORT_ZERO_MASTER_STRAP(1'b0), .I_PORT_ZERO_DIVIDER(4'h1),
      .I_SCLK(sclk_w), .O_SCLK(sclk_m), .O_SCLK_OE_B(sclk_oe_b),
      .I_FRAME_SYNC(fs_w), .O_FRAME_SYNC(fs_m), .O_FRAME_SYNC_OE_B(fs_oe_b),
      .O_SERIAL_OUT_LINE(sdo), .O_SERIAL_OUT_LINE_OE_B(sdo_oe_b),
      .O_FRAME_END(fe), .O_DATA_READY_FLAG(ready));
   sop_dsp_model dsp (
      .clk(clk), .rst_b(rst_b), .go(go), .clr(clr), .nper(6'h19),
      .sclk(sclk_w), .fs(fs_w), .sdo(sdo), .sdo_oe_b(sdo_oe_b), .fe(fe),
      .sclk_s(sclk_s), .fs_s(fs_s), .rx(rx), .fsr(fsr), .fer(fer),
      .cnt(cnt));
   sop_port #(.PORT_INDEX(0), .FIXED_SCALE(4'h2)) dut0 (
      .I_CLK(clk), .I_RST_B(rst_b), .I_ADDR(addr), .I_WDATA(wdata),
      .I_WR(wr), .I_RD(rd), .O_RDATA(rdata0), .I_SAMPLE_VALID(1'b0),
      .I_SAMPLE(sample), .I_DECIM_IS_20(decim20),
      .I_PORT_ZERO_MASTER_STRAP(1'b1), .I_PORT_ZERO_DIVIDER(4'h2),
      .I_SCLK(1'b0), .O_SCLK(), .O_SCLK_OE_B(sclk0_oe_b),
      .I_FRAME_SYNC(1'b0), .O_FRAME_SYNC(), .O_FRAME_SYNC_OE_B(),
      .O_SERIAL_OUT_LINE(), .O_SERIAL_OUT_LINE_OE_B(),
      .O_FRAME_END(), .O_DATA_READY_FLAG());
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(64'(rdata), 64'(e));
   endtask : rd_reg
   function automatic logic [63:0] lin(input logic [23:0] i,
      input logic [23:0] q, input int w);
      return (64'(i >> (24 - w)) << w) | 64'(q >> (24 - w));
   endfunction : lin
   task automatic frame(input logic [23:0] i, input logic [23:0] q,
      input int n, input logic [63:0] erx, input logic [63:0] efs,
      input logic slv);
      int k;
      @(posedge clk);
      sample <= {i, q};
      valid <= 1'b1;
      clr <= 1'b1;
      @(posedge clk);
      valid <= 1'b0;
      clr <= 1'b0;
      go <= slv;
      #1;
      chk(64'(ready), 64'h1);
      @(posedge clk);
      go <= 1'b0;
      k = 0;
      while (k < 3000 && !(cnt == 7'(n) && sdo_oe_b === 1'b1)) begin
         @(posedge clk);
         k++;
      end
      repeat (4) @(posedge clk);
      chk(64'(k < 3000), 64'h1);
      chk(64'(cnt), 64'(n));
      chk(rx, erx);
      chk(fsr, efs);
      chk(fer, 64'h1);
      chk(64'({ready, sdo_oe_b}), 64'h1);
   endtask : frame
   task automatic print_verdict;
      $display("Checks %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : print_verdict
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      int w;
      time t0;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk);
      rd_reg(OFS_FORMAT, RST_FORMAT);
      rd_reg(OFS_PORTCFG, 8'(RST_PORTCFG));
      chk(64'({sclk0_oe_b, rdata0}), 64'h012);
      rd_reg(8'h10, 8'h00);
      chk(64'({sclk_oe_b, fs_oe_b}), 64'h3);
      wr_reg(OFS_PORTCFG, 8'h11);
      rd_reg(OFS_PORTCFG, 8'h11);
      rd_reg(OFS_STATUS, 8'h04);
      chk(64'({sclk_oe_b, fs_oe_b}), 64'h0);
      for (int p = 0; p < 3; p++) begin
         for (int m = 0; m < 3; m++) begin
            w = (p == 0) ? 12 : (p == 1) ? 16 : 24;
            wr_reg(OFS_FRAME, 8'((m << 2) | p));
            frame(I0, Q0, (m == 1) ? 2 * w : 2 * w + 1, lin(I0, Q0, w),
               (m == 0) ? 64'h1 << (2 * w) : (m == 1) ?
               (64'h1 << (2 * w)) - 64'h1 :
               (64'h1 << (2 * w)) | (64'h1 << w), 1'b0);
         end
      end
      wr_reg(OFS_FRAME, 8'h00);
      wr_reg(OFS_PORTCFG, 8'h13);
      fork
         frame(I0, Q0, 25, lin(I0, Q0, 12), 64'h1 << 24, 1'b0);
         begin
            repeat (8) @(posedge sclk_m);
            t0 = $time;
            @(posedge sclk_m);
            chk(64'(($time - t0) / 20), 64'h4);
         end
      join
      wr_reg(OFS_PORTCFG, 8'h11);
      wr_reg(OFS_FORMAT, 8'h01);
      frame(24'h0A5C3E, 24'h01F0F0, 25, 64'h14B03E, 64'h1 << 24,
         1'b0);
      wr_reg(OFS_FORMAT, 8'h41);
      frame(24'h0A5C3E, 24'h01F0F0, 25, 64'h29707C, 64'h1 << 24,
         1'b0);
      wr_reg(OFS_FORMAT, 8'h10);
      frame(24'h400000, 24'hC00000, 25, 64'h400801, 64'h1 << 24,
         1'b0);
      wr_reg(OFS_FRAME, 8'h01);
      wr_reg(OFS_FORMAT, 8'h20);
      frame(24'h400000, 24'hC00000, 33, 64'h40008001, 64'h1 << 32,
         1'b0);
      wr_reg(OFS_FORMAT, 8'hA0);
      frame(24'h400000, 24'hC00000, 33, 64'h4000C000, 64'h1 << 32,
         1'b0);
      wr_reg(OFS_FRAME, 8'h00);
      wr_reg(OFS_FORMAT, 8'h90);
      decim20 <= 1'b1;
      frame(24'h400000, 24'hC00000, 21, 64'h400C0, 64'h1 << 20,
         1'b0);
      decim20 <= 1'b0;
      wr_reg(OFS_FORMAT, 8'h00);
      wr_reg(OFS_PORTCFG, 8'h01);
      rd_reg(OFS_STATUS, 8'h00);
      chk(64'({sclk_oe_b, fs_oe_b}), 64'h3);
      frame(I0, Q0, 25, lin(I0, Q0, 12), 64'h1 << 24, 1'b1);
      print_verdict();
   end
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      print_verdict();
   end
endmodule : sop_port_tb_top
